// file: verilog/aim_pkg.sv
// Constants for the record-path input mix control registers.
// Assumes an 8-bit internal register port and a one-clock sample strobe.
package aim_pkg;

	localparam int AIM_ADDR_W = 7;
	localparam int AIM_DATA_W = 8;
	localparam int AIM_GAIN_W = 7;
	localparam int AIM_ATT_W = 5;

	// Register offsets
	localparam logic [6:0] AIM_OFS_AUX_MIC_RIGHT = 7'h12;
	localparam logic [6:0] AIM_OFS_LINE_LEFT = 7'h13;

	// Reset values
	localparam logic [7:0] AIM_RST_AUX_MIC_RIGHT = 8'hFF;
	localparam logic [7:0] AIM_RST_LINE_LEFT = 8'h78;

	// Field positions, aux mic to right mix
	localparam int AIM_AUXL_LSB = 4;
	localparam int AIM_AUXR_LSB = 0;
	// Field positions, line input to left mix
	localparam int AIM_DIFF_BIT = 7;
	localparam int AIM_LINEL_LSB = 3;
	localparam int AIM_PWR_BIT = 2;
	localparam int AIM_STEP_LSB = 0;

	// Level codes
	localparam logic [3:0] AIM_LVL_MAX_ATT = 4'h8;
	localparam logic [3:0] AIM_LVL_OFF = 4'hF;
	// Attenuation per code in half-dB units (1.5 dB)
	localparam logic [4:0] AIM_ATT_PER_CODE = 5'h03;

	// Soft-step rate codes
	typedef enum logic [1:0] {
		AIM_STEP_EVERY_FS = 2'h0,
		AIM_STEP_EVERY_2FS = 2'h1,
		AIM_STEP_OFF_A = 2'h2,
		AIM_STEP_OFF_B = 2'h3
	} aim_step_t;

	// Gain code ceiling, 59.5 dB in half-dB steps
	localparam logic [6:0] AIM_GAIN_MAX = 7'h77;
	localparam logic [6:0] AIM_GAIN_RST = 7'h00;

endpackage

// file: verilog/aim_gain_walker.sv
// Left ADC gain-stage soft-stepper.
// Assumes fs_tick is a one-cycle strobe on clk, once per sample period.
`timescale 1ns/1ns
`default_nettype none
module aim_gain_walker
	import aim_pkg::*;
#(
	parameter int GAIN_W = AIM_GAIN_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire aim_step_t rate,
	input wire logic fs_tick,
	input wire logic [GAIN_W-1:0] target,
	output logic [GAIN_W-1:0] gain,
	output logic settled
);

	logic [GAIN_W-1:0] gain_r;
	logic [GAIN_W-1:0] gain_nxt;
	logic half_r;
	logic half_nxt;
	logic [GAIN_W-1:0] goal;
	logic step_now;

	always_comb begin
		// Gain saturates at the ceiling code
		goal = (target > AIM_GAIN_MAX) ? AIM_GAIN_MAX : target;
		half_nxt = half_r;
		step_now = 1'b0;
		unique case (rate)
			AIM_STEP_EVERY_FS: begin
				step_now = fs_tick;
				half_nxt = 1'b0;
			end
			AIM_STEP_EVERY_2FS: begin
				if (fs_tick) begin
					half_nxt = ~half_r;
					step_now = half_r;
				end
			end
			AIM_STEP_OFF_A, AIM_STEP_OFF_B: begin
				half_nxt = 1'b0;
			end
		endcase
		gain_nxt = gain_r;
		if (rate == AIM_STEP_OFF_A || rate == AIM_STEP_OFF_B) begin
			gain_nxt = goal;
		end else if (step_now) begin
			if (gain_r < goal) begin
				gain_nxt = gain_r + 1'b1;
			end else if (gain_r > goal) begin
				gain_nxt = gain_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gain_r <= AIM_GAIN_RST;
			half_r <= 1'b0;
		end else begin
			gain_r <= gain_nxt;
			half_r <= half_nxt;
		end
	end

	assign gain = gain_r;
	assign settled = (gain_r == goal);

endmodule
`default_nettype wire

// file: verilog/aim_mix_regs.sv
// Record-path input mix control registers and their decoded controls.
// Assumes a single-clock internal register port driven by the control-bus front end.
`timescale 1ns/1ns
`default_nettype none
module aim_mix_regs
	import aim_pkg::*;
#(
	parameter int ADDR_W = AIM_ADDR_W,
	parameter int DATA_W = AIM_DATA_W,
	parameter int GAIN_W = AIM_GAIN_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic fs_tick,
	input wire logic [GAIN_W-1:0] left_gain_target,
	output logic aux_mic_left_input_conn,
	output logic [AIM_ATT_W-1:0] aux_mic_left_input_att,
	output logic aux_mic_right_input_conn,
	output logic [AIM_ATT_W-1:0] aux_mic_right_input_att,
	output logic first_line_left_input_conn,
	output logic [AIM_ATT_W-1:0] first_line_left_input_att,
	output logic first_line_left_input_diff,
	output logic left_adc_power_up,
	output logic left_soft_step_on,
	output logic [GAIN_W-1:0] left_gain,
	output logic left_gain_settled,
	output logic reserved_code_seen
);

	// Connect decision for a level code
	function automatic logic lvl_conn(input logic [3:0] code);
		lvl_conn = (code <= AIM_LVL_MAX_ATT);
	endfunction

	// Attenuation in half-dB units, zero when not connected
	function automatic logic [AIM_ATT_W-1:0] lvl_att(input logic [3:0] code);
		logic [7:0] prod;
		prod = 8'({4'h0, code}) * 8'({3'h0, AIM_ATT_PER_CODE});
		lvl_att = lvl_conn(code) ? prod[AIM_ATT_W-1:0] : '0;
	endfunction

	// Reserved code detect
	function automatic logic lvl_rsvd(input logic [3:0] code);
		lvl_rsvd = (code > AIM_LVL_MAX_ATT) && (code != AIM_LVL_OFF);
	endfunction

	logic [DATA_W-1:0] aux_mic_to_right_mix_r;
	logic [DATA_W-1:0] aux_mic_to_right_mix_nxt;
	logic [DATA_W-1:0] line_in_left_mix_power_step_r;
	logic [DATA_W-1:0] line_in_left_mix_power_step_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic rsvd_r;
	logic rsvd_nxt;

	logic [3:0] auxl_code;
	logic [3:0] auxr_code;
	logic [3:0] linel_code;
	aim_step_t step_rate;
	logic hit_aux;
	logic hit_line;

	assign hit_aux = (reg_addr == AIM_OFS_AUX_MIC_RIGHT[ADDR_W-1:0]);
	assign hit_line = (reg_addr == AIM_OFS_LINE_LEFT[ADDR_W-1:0]);

	assign auxl_code = aux_mic_to_right_mix_r[AIM_AUXL_LSB +: 4];
	assign auxr_code = aux_mic_to_right_mix_r[AIM_AUXR_LSB +: 4];
	assign linel_code = line_in_left_mix_power_step_r[AIM_LINEL_LSB +: 4];
	assign step_rate = aim_step_t'(line_in_left_mix_power_step_r[AIM_STEP_LSB +: 2]);

	// Register writes and read port
	always_comb begin
		aux_mic_to_right_mix_nxt = aux_mic_to_right_mix_r;
		line_in_left_mix_power_step_nxt = line_in_left_mix_power_step_r;
		rsvd_nxt = rsvd_r;
		if (reg_wr && hit_aux) begin
			aux_mic_to_right_mix_nxt = reg_wdata;
			rsvd_nxt = rsvd_r | lvl_rsvd(reg_wdata[AIM_AUXL_LSB +: 4])
				| lvl_rsvd(reg_wdata[AIM_AUXR_LSB +: 4]);
		end
		if (reg_wr && hit_line) begin
			line_in_left_mix_power_step_nxt = reg_wdata;
			rsvd_nxt = rsvd_r | lvl_rsvd(reg_wdata[AIM_LINEL_LSB +: 4]);
		end
		rvalid_nxt = reg_rd;
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			if (hit_aux) begin
				rdata_nxt = aux_mic_to_right_mix_r;
			end else if (hit_line) begin
				rdata_nxt = line_in_left_mix_power_step_r;
			end else begin
				rdata_nxt = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_mic_to_right_mix_r <= AIM_RST_AUX_MIC_RIGHT;
			line_in_left_mix_power_step_r <= AIM_RST_LINE_LEFT;
			rdata_r <= '0;
			rvalid_r <= 1'b0;
			rsvd_r <= 1'b0;
		end else begin
			aux_mic_to_right_mix_r <= aux_mic_to_right_mix_nxt;
			line_in_left_mix_power_step_r <= line_in_left_mix_power_step_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			rsvd_r <= rsvd_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign reserved_code_seen = rsvd_r;

	assign aux_mic_left_input_conn = lvl_conn(auxl_code);
	assign aux_mic_left_input_att = lvl_att(auxl_code);
	// and code 1111 leaves connect low via lvl_conn

	assign aux_mic_right_input_conn = lvl_conn(auxr_code);
	assign aux_mic_right_input_att = lvl_att(auxr_code);

	assign first_line_left_input_conn = lvl_conn(linel_code);
	assign first_line_left_input_att = lvl_att(linel_code);
	assign first_line_left_input_diff = line_in_left_mix_power_step_r[AIM_DIFF_BIT];
	assign left_adc_power_up = line_in_left_mix_power_step_r[AIM_PWR_BIT];
	// stepping enabled only for 00 and 01
	assign left_soft_step_on = (step_rate == AIM_STEP_EVERY_FS)
		|| (step_rate == AIM_STEP_EVERY_2FS);

	aim_gain_walker #(
		.GAIN_W(GAIN_W)
	) u_walker (
		.clk(clk),
		.rst_b(rst_b),
		.rate(step_rate),
		.fs_tick(fs_tick),
		.target(left_gain_target),
		.gain(left_gain),
		.settled(left_gain_settled)
	);

endmodule
`default_nettype wire

// file: test/aim_mix_chk.sv
// Checker for the input mix control registers.
// Assumes it is bound to aim_mix_regs and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module aim_mix_chk
	import aim_pkg::*;
#(
	parameter int GAIN_W = AIM_GAIN_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fs_tick,
	input wire logic [GAIN_W-1:0] left_gain_target,
	input wire logic aux_mic_left_input_conn,
	input wire logic [AIM_ATT_W-1:0] aux_mic_left_input_att,
	input wire logic first_line_left_input_conn,
	input wire logic [AIM_ATT_W-1:0] first_line_left_input_att,
	input wire logic left_soft_step_on,
	input wire logic [GAIN_W-1:0] left_gain,
	input wire logic left_gain_settled
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_AUXL_SCALE: assert property (
		aux_mic_left_input_conn |-> aux_mic_left_input_att % 3 == 0 && aux_mic_left_input_att <= 24)
		else $error("aux left attenuation off scale");
	AST_AUXL_OFF: assert property (
		!aux_mic_left_input_conn |-> aux_mic_left_input_att == 5'h00)
		else $error("aux left attenuation while off");
	AST_LINE_SCALE: assert property (
		first_line_left_input_conn |-> first_line_left_input_att <= 24)
		else $error("line attenuation off scale");
	AST_LINE_OFF: assert property (
		!first_line_left_input_conn |-> first_line_left_input_att == 5'h00)
		else $error("line attenuation while off");
	AST_GAIN_MAX: assert property (left_gain <= AIM_GAIN_MAX)
		else $error("gain above ceiling");
	AST_STEP_ONE: assert property (
		$past(left_soft_step_on) && $changed(left_gain)
		|-> left_gain - $past(left_gain) == 7'h01 || $past(left_gain) - left_gain == 7'h01)
		else $error("gain moved more than one step");
	AST_NO_TICK: assert property (
		left_soft_step_on && $past(left_soft_step_on) && !$past(fs_tick) |-> $stable(left_gain))
		else $error("gain moved without a tick");
	AST_JUMP: assert property (
		!left_soft_step_on && !$past(left_soft_step_on) && $stable(left_gain_target)
		|-> left_gain_settled)
		else $error("gain not at target with stepping off");
endmodule
bind aim_mix_regs aim_mix_chk #(.GAIN_W(GAIN_W)) u_chk (.clk, .rst_b, .fs_tick, .left_gain_target,
	.aux_mic_left_input_conn, .aux_mic_left_input_att, .first_line_left_input_conn,
	.first_line_left_input_att, .left_soft_step_on, .left_gain, .left_gain_settled);
`default_nettype wire

// file: test/tb_top.sv
// Testbench for the input mix control registers with a bench-side model.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import aim_pkg::*;
;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, fs_tick = 0, rvalid;
	logic al_c, ar_c, ll_c, diff, pwr, son, g_ok, rsv, ph, rs;
	logic [6:0] reg_addr = 7'h00, tgt = 7'h00, eg, gain;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, m12, m13, d;
	logic [4:0] al_att, ar_att, ll_att;
	integer seed = 98507, err_total = 0, comparisons = 0, i, c;
	always #50 clk = ~clk;
	aim_mix_regs dut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.reg_rvalid(rvalid), .fs_tick, .left_gain_target(tgt), .aux_mic_left_input_conn(al_c),
		.aux_mic_left_input_att(al_att), .aux_mic_right_input_conn(ar_c),
		.aux_mic_right_input_att(ar_att), .first_line_left_input_conn(ll_c),
		.first_line_left_input_att(ll_att), .first_line_left_input_diff(diff),
		.left_adc_power_up(pwr), .left_soft_step_on(son), .left_gain(gain),
		.left_gain_settled(g_ok), .reserved_code_seen(rsv));
	function automatic logic [6:0] clamp(input logic [6:0] t);
		return t > AIM_GAIN_MAX ? AIM_GAIN_MAX : t;
	endfunction
	function automatic logic bad(input logic [3:0] k);
		return k > 4'h8 && k < 4'hF;
	endfunction
	// Model of registers and gain walk
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			m12 = AIM_RST_AUX_MIC_RIGHT;
			m13 = AIM_RST_LINE_LEFT;
			eg = 7'h00;
			ph = 0;
			rs = 0;
		end else begin
			if (m13[1])
				eg = clamp(tgt);
			else if (fs_tick && (!m13[0] || ph))
				eg = eg + (eg < clamp(tgt)) - (eg > clamp(tgt));
			ph = m13[1:0] == 2'h1 && (ph ^ fs_tick);
			if (reg_wr && reg_addr == AIM_OFS_AUX_MIC_RIGHT) begin
				rs = rs | bad(reg_wdata[7:4]) | bad(reg_wdata[3:0]);
				m12 = reg_wdata;
			end
			if (reg_wr && reg_addr == AIM_OFS_LINE_LEFT) begin
				rs = rs | bad(reg_wdata[6:3]);
				m13 = reg_wdata;
			end
		end
	end
	// Sample away from both edges, stimulus moves at the falling one
	always @(posedge clk) begin
		#20;
		if (rst_b) begin
			chk(gain, eg);
			chk(g_ok, eg == clamp(tgt));
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk);
		reg_rd = 0;
		chk(rvalid, 1);
		chk(reg_rdata, e);
	endtask
	task automatic field(input logic c, input logic [4:0] a, input logic [3:0] k);
		chk(c, k <= 4'h8);
		chk(a, k <= 4'h8 ? {1'b0, k} * 5'h03 : 5'h00);
	endtask
	task automatic decode;
		field(al_c, al_att, m12[7:4]);
		field(ar_c, ar_att, m12[3:0]);
		field(ll_c, ll_att, m13[6:3]);
		chk(diff, m13[7]);
		chk(pwr, m13[2]);
		chk(son, !m13[1]);
		chk(rsv, rs);
		rd(AIM_OFS_AUX_MIC_RIGHT, m12);
		rd(AIM_OFS_LINE_LEFT, m13);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1;
		decode;
		rd(7'h14, 8'h00);
		$display("test reset done");
		for (c = 0; c < 16; c++) begin
			if (!bad(c[3:0])) begin
				d = $random(seed);
				wr(AIM_OFS_AUX_MIC_RIGHT, {c[3:0], (c[3:0] == 4'hF ? 4'h0 : 4'h8 - c[3:0])});
				// only the left route exists here
				wr(AIM_OFS_LINE_LEFT, {d[7], c[3:0], d[2:0]});
				decode;
			end
		end
		wr(7'h14, 8'h00);
		decode;
		$display("test codes done");
		for (c = 0; c < 4; c++) begin
			wr(AIM_OFS_LINE_LEFT, {5'h0F, c[0], c[1:0]});
			for (i = 0; i < 80; i++) begin
				@(negedge clk);
				fs_tick = $random(seed) % 3 == 0;
				if (i % 25 == 0)
					tgt = $random(seed);
			end
			@(negedge clk);
			fs_tick = 0;
			decode;
		end
		$display("test stepping done");
		wr(AIM_OFS_AUX_MIC_RIGHT, 8'h9F);
		decode;
		$display("test reserved done");
		conclude;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		conclude;
	end
endmodule
`default_nettype wire
